// ### hdl/mcr_defs.svh
`ifndef MCR_DEFS_SVH
`define MCR_DEFS_SVH

// register addresses on ad[2:0]
`define MCR_A_LINE      3'h0
`define MCR_A_IFTEST    3'h1
`define MCR_A_DETECT    3'h2
`define MCR_A_TONE      3'h3
`define MCR_A_DSP       3'h4
`define MCR_A_GAIN      3'h5
`define MCR_A_SIG       3'h6

// field positions
`define MCR_B_ANSORIG   0
`define MCR_B_TXEN      1
`define MCR_B_MODOPT    7
`define MCR_B_SWRESET   2
`define MCR_B_CLKCTL    3
`define MCR_B_BYPASS    4
`define MCR_B_INTEN     5
`define MCR_B_SPECACC   6
`define MCR_B_CALLINIT  5
`define MCR_B_TR_SEL    0
`define MCR_B_TR_DTMF   4
`define MCR_B_TR_ANS    5
`define MCR_B_TR_GUARD  6

// reset values and masks
`define MCR_RST_ZERO    8'h00
`define MCR_RST_GAIN    8'h04
`define MCR_KEEP_GAIN   8'h04
`define MCR_EVT_MASK    8'h5e
`define MCR_TXEN_MASK   8'h06
`define MCR_DTMF_MASK   8'h08
// arbitrary signature value, names no real part
`define MCR_SIG_CODE    4'h5
`define MCR_BUS_IDLE    12'hf00

// timing
`define MCR_CLK_HZ      100000000
`define MCR_CLKOUT_MULT 16
`define MCR_HALF(r)     (`MCR_CLK_HZ / (`MCR_CLKOUT_MULT * (r) * 2))

`endif

// ### hdl/mcr_pkg.sv
`default_nettype none
package mcr_pkg;
	typedef enum logic [1:0] {MCR_MOD_QAM, MCR_MOD_DPSK, MCR_MOD_FSK, MCR_MOD_NONE} mcr_mod_t;
	typedef enum logic [2:0] {MCR_RATE_2400, MCR_RATE_1200, MCR_RATE_600, MCR_RATE_300,
		MCR_RATE_V21, MCR_RATE_NONE} mcr_rate_t;
	typedef enum logic [2:0] {MCR_XM_POWER_DOWN, MCR_XM_SYNC_INT, MCR_XM_SYNC_EXT,
		MCR_XM_SYNC_SLAVE, MCR_XM_ASYNC, MCR_XM_FSK} mcr_xmode_t;
	typedef enum logic [1:0] {MCR_TEST_NORMAL, MCR_TEST_ANALOG_LOOP, MCR_TEST_REMOTE_DLOOP,
		MCR_TEST_LOCAL_DLOOP} mcr_test_t;
	typedef enum logic [1:0] {MCR_DET_2225, MCR_DET_2100, MCR_DET_SCT_900,
		MCR_DET_EITHER} mcr_det_tone_t;

	typedef struct packed {
		logic rx_level;
		logic s1_pattern;
		logic rx_data;
		logic unscr_mark;
		logic carrier;
		logic special_tone;
		logic call_progress;
		logic sig_quality;
	} mcr_detect_t;

	typedef struct packed {
		logic          tx_low_band;
		logic          rx_high_band;
		logic          tx_enable;
		mcr_xmode_t    xmode;
		logic [3:0]    char_bits;
		logic [3:0]    data_bits;
		mcr_mod_t      modulation;
		mcr_rate_t     rate;
		mcr_test_t     test;
		logic          rx_use_tx_carrier;
		logic          power_down;
		logic          scr_bypass;
		logic [1:0]    tx_pattern;
		logic          eq_enable;
		logic          train_inhibit;
		logic          dsp_run;
		logic          sixteen_way;
		logic          tx_s1;
		logic          call_init;
		logic [3:0]    tx_atten;
		logic          rx_boost;
		logic          off_hook;
		logic          clk_tristate;
		logic          txd_alt;
		logic          txd_source;
		logic [1:0]    quality_threshold_sel;
		logic          rxd_enable;
	} mcr_modem_ctl_t;

	typedef struct packed {
		logic          dual_tone_send;
		logic [3:0]    dtmf_code;
		logic          guard_550;
		logic          calling_1300;
		logic          answer_tone;
		logic          answer_2100;
		mcr_det_tone_t det_tone;
	} mcr_tone_ctl_t;
endpackage
`default_nettype wire

// ### hdl/mcr_sync2.sv
`default_nettype none
module mcr_sync2 #(
	parameter int          WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic [WIDTH-1:0] d_i,
	output logic      [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			meta <= RST_VAL;
			q_o  <= RST_VAL;
		end
		else
		begin
			meta <= d_i;
			q_o  <= meta;
		end
	end
endmodule
`default_nettype wire

// ### hdl/mcr_clkdiv.sv
`default_nettype none
module mcr_clkdiv #(
	parameter int WIDTH = 13
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic [WIDTH-1:0] half_i,
	output logic                  tick_o
);
	logic [WIDTH-1:0] cnt;

	// one-cycle pulse every half_i cycles
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cnt    <= '0;
			tick_o <= 1'b0;
		end
		else if (cnt + WIDTH'(1) >= half_i)
		begin
			cnt    <= '0;
			tick_o <= 1'b1;
		end
		else
		begin
			cnt    <= cnt + WIDTH'(1);
			tick_o <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ### hdl/mcr_bank.sv
// What this block does
// RULE1: answer/originate 1 sends low band, receives high; 0 the reverse
// RULE2: async codes select 8 to 11 bit characters, 6 to 9 data bits
// RULE3: data source keeps sync transmit bits valid at transmit clock rising edge
// RULE4: option 0: QAM 2400, DPSK 1200, FSK 300; option 1: DPSK 600, V.21
// RULE5: test field: normal, analog loop, remote digital loop, local digital loop
// RULE6: software reset powers down, clears controls and tones except gain bit two
// RULE7: clock pin echoes crystal, or sixteen times data rate in DPSK/QAM
// RULE8: bypass bit routes DPSK and QAM transmit data around the scrambler
// RULE9: interrupt enable raises interrupt on change of detect bits 1-4 or 6
// RULE10: transmit enable masks answer tone and call progress interrupts
// RULE11: active dual tone sending masks the carrier detect interrupt
// RULE12: power-down disables all interrupts regardless of the enable bit
// RULE13: quality flag reads 1 on poor signal; threshold from quality select bits
// RULE14: special tone flag meaning follows answer/originate, tone select, call init
// RULE15: carrier flag reads 1 while a carrier is received
// RULE16: S1 flag reads 1 while aligned 001100 dibit pattern is received
// RULE17: receive level flag reads 0 below about -25 dBm0, else 1
// RULE18: guard bit, answer mode, select 1, no dual tone: send 550 Hz guard tone
// RULE19: guard bit, originate mode, select 0: send 1300 Hz calling tone
// RULE20: host writes zero into every reserved bit
// RULE21: signature register returns a four-bit code in its upper bits
// RULE22: special register shares address 5 with the gain register
// RULE23: special register reached only while special access bit is set
// RULE24: dual tone pair chosen by send bit and four code bits
// RULE25: interrupt stays asserted until detect register read or full reset; the pin also releases when the enable bit clears or in power-down
`default_nettype none
`include "mcr_defs.svh"
module mcr_bank #(
	parameter int HALF_2400 = `MCR_HALF(2400),
	parameter int HALF_1200 = `MCR_HALF(1200),
	parameter int HALF_600  = `MCR_HALF(600)
) (
	input  wire logic                    clk_i,
	input  wire logic                    rst_n_i,
	input  wire logic                    ale_i,
	input  wire logic                    cs_n_i,
	input  wire logic                    rd_n_i,
	input  wire logic                    wr_n_i,
	input  wire logic [7:0]              ad_i,
	output logic      [7:0]              ad_o,
	output logic                         ad_oe_o,
	output logic                         int_o,
	output logic                         int_oe_o,
	input  wire mcr_pkg::mcr_detect_t    detect_i,
	input  wire logic                    tx_baud_clk_i,
	input  wire logic                    rx_unscr_data_i,
	input  wire logic                    xtal_echo_i,
	output logic                         clk_pin_o,
	output mcr_pkg::mcr_modem_ctl_t      modem_o,
	output mcr_pkg::mcr_tone_ctl_t       tone_o
);
	import mcr_pkg::*;

	logic [11:0]    bus_s;
	logic           ale_s;
	logic           cs_n_s;
	logic           rd_n_s;
	logic           wr_n_s;
	logic [7:0]     ad_s;
	logic           ale_q;
	logic           rd_q;
	logic           wr_q;
	logic [2:0]     addr_q;
	logic           sel_q;
	logic           wr_go;
	logic           rd_end;
	logic [7:0]     line_mode_control;
	logic [7:0]     interface_test_control;
	logic [7:0]     tone_control;
	logic [6:0]     dsp_control;
	logic [7:0]     gain_attenuation_control;
	logic [3:1]     special_rw;
	logic [7:0]     detect_status;
	logic [7:0]     det_q;
	logic [7:0]     evt_mask;
	logic [7:0]     rdata;
	logic           int_pend;
	logic           pwr_down;
	logic           int_en;
	mcr_mod_t       next_mod;
	logic [12:0]    half_sel;
	logic           tick;
	logic           clk16_q;
	logic           special_sel;

	mcr_sync2 #(
		.WIDTH   (12),
		.RST_VAL (`MCR_BUS_IDLE)
	) u_sync (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.d_i     ({ale_i, cs_n_i, rd_n_i, wr_n_i, ad_i}),
		.q_o     (bus_s)
	);

	assign {ale_s, cs_n_s, rd_n_s, wr_n_s, ad_s} = bus_s;

	// address and chip select latched on the falling edge of ale
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ale_q  <= 1'b1;
			rd_q   <= 1'b1;
			wr_q   <= 1'b1;
			addr_q <= 3'h0;
			sel_q  <= 1'b0;
		end
		else
		begin
			ale_q <= ale_s;
			rd_q  <= rd_n_s;
			wr_q  <= wr_n_s;
			if (ale_q && !ale_s)
			begin
				addr_q <= ad_s[2:0];
				sel_q  <= !cs_n_s;
			end
		end
	end

	assign wr_go       = sel_q && !wr_q && wr_n_s;
	assign rd_end      = sel_q && !rd_q && rd_n_s;
	assign special_sel = dsp_control[`MCR_B_SPECACC]; // [RULE23]

	// register writes; data taken on the rising edge of write
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			line_mode_control        <= `MCR_RST_ZERO;
			interface_test_control   <= `MCR_RST_ZERO;
			tone_control             <= `MCR_RST_ZERO;
			dsp_control              <= 7'h00;
			gain_attenuation_control <= `MCR_RST_GAIN;
			special_rw               <= 3'h0;
		end
		else if (wr_go)
		begin
			if (addr_q == `MCR_A_IFTEST && ad_s[`MCR_B_SWRESET])
			begin
				line_mode_control        <= `MCR_RST_ZERO; // [RULE6]
				interface_test_control   <= `MCR_RST_ZERO; // [RULE6]
				tone_control             <= `MCR_RST_ZERO; // [RULE6]
				dsp_control              <= 7'h00; // [RULE6]
				gain_attenuation_control <= gain_attenuation_control & `MCR_KEEP_GAIN; // [RULE6]
				special_rw               <= 3'h0; // [RULE6]
			end
			else
			begin
				case (addr_q)
					`MCR_A_LINE:   line_mode_control <= ad_s;
					`MCR_A_IFTEST: interface_test_control <= ad_s;
					`MCR_A_TONE:   tone_control <= ad_s;
					`MCR_A_DSP:    dsp_control <= ad_s[6:0];
					`MCR_A_GAIN:
					begin
						if (special_sel)
							special_rw <= ad_s[3:1]; // [RULE22] [RULE23]
						else
							gain_attenuation_control <= ad_s; // [RULE22]
					end
					default: ;
				endcase
			end
		end
	end

	// flags reported straight from the datapath monitors
	assign detect_status = detect_i; // [RULE13] [RULE15] [RULE16] [RULE17]

	always_comb
	begin
		case (addr_q)
			`MCR_A_LINE:   rdata = line_mode_control;
			`MCR_A_IFTEST: rdata = interface_test_control;
			`MCR_A_DETECT: rdata = detect_status;
			`MCR_A_TONE:   rdata = tone_control;
			`MCR_A_DSP:    rdata = {1'b0, dsp_control};
			`MCR_A_GAIN:
			begin
				if (special_sel)
					rdata = {1'b0, tx_baud_clk_i, rx_unscr_data_i, 1'b0,
						special_rw, 1'b0}; // [RULE23]
				else
					rdata = gain_attenuation_control;
			end
			`MCR_A_SIG:    rdata = {`MCR_SIG_CODE, 4'h0}; // [RULE21]
			default:       rdata = 8'h00;
		endcase
	end

	// read data driven while read is low and the latched select is set
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ad_o    <= 8'h00;
			ad_oe_o <= 1'b0;
		end
		else
		begin
			ad_o    <= rdata;
			ad_oe_o <= sel_q && !rd_n_s;
		end
	end

	assign pwr_down = line_mode_control[5:2] == 4'h0;
	assign int_en   = interface_test_control[`MCR_B_INTEN];

	assign evt_mask = `MCR_EVT_MASK & ~({8{line_mode_control[`MCR_B_TXEN]}} & `MCR_TXEN_MASK) &
		~({8{tone_control[`MCR_B_TR_DTMF]}} & `MCR_DTMF_MASK); // [RULE9] [RULE10] [RULE11]

	// a change seen in the cycle of the clearing read still wins
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			det_q    <= 8'h00;
			int_pend <= 1'b0;
			int_oe_o <= 1'b0;
		end
		else
		begin
			det_q <= detect_status;
			if (((detect_status ^ det_q) & evt_mask) != 8'h00 && int_en && !pwr_down)
				int_pend <= 1'b1; // [RULE9] [RULE12]
			else if (rd_end && addr_q == `MCR_A_DETECT)
				int_pend <= 1'b0; // [RULE25]
			// open drain: pulled low while pending, enabled and not powered down
			int_oe_o <= int_pend && int_en && !pwr_down; // [RULE9] [RULE12] [RULE25]
		end
	end

	assign int_o = 1'b0;

	always_comb
	begin
		case (line_mode_control[6:5])
			2'b10:   next_mod = MCR_MOD_QAM;
			2'b00:   next_mod = MCR_MOD_DPSK;
			2'b01:   next_mod = MCR_MOD_FSK;
			default: next_mod = MCR_MOD_NONE;
		endcase
	end

	assign half_sel = next_mod == MCR_MOD_QAM ? 13'(HALF_2400) :
		line_mode_control[`MCR_B_MODOPT] ? 13'(HALF_600) : 13'(HALF_1200);
	mcr_clkdiv #(
		.WIDTH   (13)
	) u_div (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.half_i  (half_sel),
		.tick_o  (tick)
	);

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			clk16_q <= 1'b0;
		else if (tick)
			clk16_q <= !clk16_q;
	end

	// crystal echo unless the rate clock is chosen in DPSK or QAM
	assign clk_pin_o = (interface_test_control[`MCR_B_CLKCTL] &&
		(next_mod == MCR_MOD_QAM || next_mod == MCR_MOD_DPSK)) ? clk16_q : xtal_echo_i; // [RULE7]

	// decoded controls toward the datapath
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			modem_o <= '0;
		else
		begin
			modem_o.tx_low_band  <= line_mode_control[`MCR_B_ANSORIG]; // [RULE1]
			modem_o.rx_high_band <= line_mode_control[`MCR_B_ANSORIG]; // [RULE1]
			modem_o.tx_enable    <= line_mode_control[`MCR_B_TXEN];
			modem_o.char_bits    <= 4'h8 + {2'b00, line_mode_control[3:2]}; // [RULE2]
			modem_o.data_bits    <= 4'h6 + {2'b00, line_mode_control[3:2]}; // [RULE2]
			case (line_mode_control[5:2])
				4'h0:    modem_o.xmode <= MCR_XM_POWER_DOWN;
				4'h1:    modem_o.xmode <= MCR_XM_SYNC_INT;
				4'h2:    modem_o.xmode <= MCR_XM_SYNC_EXT;
				4'h3:    modem_o.xmode <= MCR_XM_SYNC_SLAVE;
				4'h4, 4'h5, 4'h6, 4'h7:
					modem_o.xmode <= MCR_XM_ASYNC; // [RULE2]
				4'h8, 4'hc:
					modem_o.xmode <= MCR_XM_FSK;
				default: modem_o.xmode <= MCR_XM_POWER_DOWN;
			endcase
			modem_o.modulation <= next_mod;
			case (next_mod)
				MCR_MOD_QAM:  modem_o.rate <= line_mode_control[`MCR_B_MODOPT] ?
					MCR_RATE_NONE : MCR_RATE_2400; // [RULE4]
				MCR_MOD_DPSK: modem_o.rate <= line_mode_control[`MCR_B_MODOPT] ?
					MCR_RATE_600 : MCR_RATE_1200; // [RULE4]
				MCR_MOD_FSK:  modem_o.rate <= line_mode_control[`MCR_B_MODOPT] ?
					MCR_RATE_V21 : MCR_RATE_300; // [RULE4]
				default:      modem_o.rate <= MCR_RATE_NONE;
			endcase
			case (interface_test_control[1:0])
				2'b00:   modem_o.test <= MCR_TEST_NORMAL; // [RULE5]
				2'b01:   modem_o.test <= MCR_TEST_ANALOG_LOOP; // [RULE5]
				2'b10:   modem_o.test <= MCR_TEST_REMOTE_DLOOP; // [RULE5]
				default: modem_o.test <= MCR_TEST_LOCAL_DLOOP; // [RULE5]
			endcase
			modem_o.rx_use_tx_carrier <= interface_test_control[1:0] == 2'b01; // [RULE5]
			modem_o.power_down    <= pwr_down; // [RULE6]
			modem_o.scr_bypass    <= interface_test_control[`MCR_B_BYPASS] &&
				(next_mod == MCR_MOD_QAM || next_mod == MCR_MOD_DPSK); // [RULE8]
			modem_o.tx_pattern    <= interface_test_control[7:6];
			modem_o.eq_enable     <= dsp_control[0];
			modem_o.train_inhibit <= dsp_control[1];
			modem_o.dsp_run       <= dsp_control[2];
			modem_o.sixteen_way   <= dsp_control[3];
			modem_o.tx_s1         <= dsp_control[4];
			modem_o.call_init     <= dsp_control[`MCR_B_CALLINIT];
			modem_o.tx_atten      <= gain_attenuation_control[3:0];
			modem_o.rx_boost      <= gain_attenuation_control[4];
			modem_o.off_hook      <= gain_attenuation_control[5];
			modem_o.clk_tristate  <= gain_attenuation_control[6];
			modem_o.txd_alt       <= gain_attenuation_control[7];
			modem_o.txd_source    <= special_rw[3];
			modem_o.quality_threshold_sel <= special_rw[2:1]; // [RULE13]
			modem_o.rxd_enable    <= !tone_control[7];
		end
	end

	// tone generator controls; the dual tone bit overrides the answer, guard and calling tones
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			tone_o <= '0;
		else
		begin
			tone_o.dual_tone_send <= tone_control[`MCR_B_TR_DTMF] &&
				line_mode_control[`MCR_B_TXEN]; // [RULE24]
			tone_o.dtmf_code      <= tone_control[3:0]; // [RULE24]
			tone_o.guard_550      <= tone_control[`MCR_B_TR_GUARD] &&
				!tone_control[`MCR_B_TR_ANS] && !tone_control[`MCR_B_TR_DTMF] &&
				tone_control[`MCR_B_TR_SEL] && !line_mode_control[`MCR_B_ANSORIG] &&
				(next_mod == MCR_MOD_QAM || next_mod == MCR_MOD_DPSK); // [RULE18]
			tone_o.calling_1300   <= tone_control[`MCR_B_TR_GUARD] &&
				!tone_control[`MCR_B_TR_ANS] && !tone_control[`MCR_B_TR_DTMF] &&
				!tone_control[`MCR_B_TR_SEL] && line_mode_control[`MCR_B_ANSORIG] &&
				next_mod != MCR_MOD_NONE; // [RULE19]
			tone_o.answer_tone    <= tone_control[`MCR_B_TR_ANS] &&
				!tone_control[`MCR_B_TR_DTMF];
			tone_o.answer_2100    <= tone_control[`MCR_B_TR_SEL];
			case ({line_mode_control[`MCR_B_ANSORIG], tone_control[`MCR_B_TR_SEL],
				dsp_control[`MCR_B_CALLINIT]})
				3'b101:  tone_o.det_tone <= MCR_DET_2225; // [RULE14]
				3'b111:  tone_o.det_tone <= MCR_DET_2100; // [RULE14]
				3'b000, 3'b010:
					tone_o.det_tone <= MCR_DET_SCT_900; // [RULE14]
				3'b100, 3'b110:
					tone_o.det_tone <= MCR_DET_EITHER; // [RULE14]
				default: tone_o.det_tone <= MCR_DET_EITHER;
			endcase
		end
	end
endmodule
`default_nettype wire

// ### test/mcr_bank_chk.sv
`default_nettype none
`include "mcr_defs.svh"
module mcr_bank_chk (
	input wire logic                    clk_i,
	input wire logic                    rst_n_i,
	input wire logic                    ale_i,
	input wire logic                    cs_n_i,
	input wire logic                    rd_n_i,
	input wire logic [7:0]              ad_i,
	input wire logic [7:0]              ad_o,
	input wire logic                    ad_oe_o,
	input wire logic                    int_oe_o,
	input wire logic                    xtal_echo_i,
	input wire logic                    clk_pin_o,
	input wire mcr_pkg::mcr_modem_ctl_t modem_o,
	input wire mcr_pkg::mcr_tone_ctl_t  tone_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import mcr_pkg::*;

	logic       ale_q;
	logic       unsel_q;
	logic [2:0] addr_q;
	logic [3:0] since_det;

	// select and address as the pins stood at the last ale fall
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ale_q   <= 1'b0;
			unsel_q <= 1'b1;
			addr_q  <= 3'h0;
		end
		else
		begin
			ale_q <= ale_i;
			if (ale_q && !ale_i)
			begin
				unsel_q <= cs_n_i;
				addr_q  <= ad_i[2:0];
			end
		end
	end

	// cycles since a selected detect read was last in progress
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			since_det <= 4'hf;
		else if (!rd_n_i && !unsel_q && addr_q == `MCR_A_DETECT)
			since_det <= 4'h0;
		else if (since_det != 4'hf)
			since_det <= since_det + 4'h1;
	end

	default clocking dc @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	a_band_split: assert property (modem_o.test != MCR_TEST_ANALOG_LOOP |->
		modem_o.tx_low_band == modem_o.rx_high_band)
		else $error("band split mismatch");
	a_char_frame: assert property (modem_o.xmode == MCR_XM_ASYNC |->
		modem_o.char_bits == modem_o.data_bits + 4'h2 && modem_o.data_bits inside {[6:9]})
		else $error("async framing wrong");
	a_dpsk_rate: assert property (modem_o.modulation == MCR_MOD_DPSK |->
		modem_o.rate inside {MCR_RATE_1200, MCR_RATE_600})
		else $error("dpsk rate wrong");
	a_analog_loop: assert property (
		modem_o.rx_use_tx_carrier == (modem_o.test == MCR_TEST_ANALOG_LOOP))
		else $error("analog loop carrier wrong");
	a_crystal_echo: assert property (modem_o.modulation == MCR_MOD_FSK |->
		$past(clk_pin_o) == $past(xtal_echo_i))
		else $error("clock pin not echoing crystal");
	a_pd_no_int: assert property (modem_o.power_down [*3] |-> !$rose(int_oe_o))
		else $error("interrupt raised in power-down");
	a_guard_tone: assert property (tone_o.guard_550 |->
		!modem_o.tx_low_band && !tone_o.dual_tone_send)
		else $error("guard tone outside answer mode");
	a_calling_tone: assert property (tone_o.calling_1300 |-> modem_o.tx_low_band)
		else $error("calling tone outside originate mode");
	a_sig_code: assert property (ad_oe_o && !unsel_q && addr_q == `MCR_A_SIG |->
		ad_o[7:4] == `MCR_SIG_CODE)
		else $error("signature code wrong");
	a_int_hold: assert property ($fell(int_oe_o) |-> since_det < 4'h8)
		else $error("interrupt dropped without detect read");
endmodule

bind mcr_bank mcr_bank_chk chk_u (
	.clk_i      (clk_i),
	.rst_n_i    (rst_n_i),
	.ale_i      (ale_i),
	.cs_n_i     (cs_n_i),
	.rd_n_i     (rd_n_i),
	.ad_i       (ad_i),
	.ad_o       (ad_o),
	.ad_oe_o    (ad_oe_o),
	.int_oe_o   (int_oe_o),
	.xtal_echo_i(xtal_echo_i),
	.clk_pin_o  (clk_pin_o),
	.modem_o    (modem_o),
	.tone_o     (tone_o)
);
`default_nettype wire

// ### test/mcr_host_model.sv
`default_nettype none
module mcr_host_model (
	input  wire logic       clk_i,
	input  wire logic [7:0] dev_ad_i,
	input  wire logic       dev_oe_i,
	output logic            ale_o,
	output logic            cs_n_o,
	output logic            rd_n_o,
	output logic            wr_n_o,
	output logic [7:0]      ad_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       drv;
	logic [7:0] hv;
	logic [7:0] last;

	initial
	begin
		ale_o = 1'b0;
		cs_n_o = 1'b1;
		rd_n_o = 1'b1;
		wr_n_o = 1'b1;
		drv = 1'b0;
		hv = 8'h00;
		last = 8'h00;
	end

	// a floating bus shows a pattern that changes every cycle
	assign ad_o = dev_oe_i ? dev_ad_i : drv ? hv : ~last;
	always @(posedge clk_i) last <= ad_o;

	task automatic addr_phase(input logic [2:0] a, input logic sel);
		@(posedge clk_i);
		ale_o <= 1'b1;
		cs_n_o <= ~sel;
		drv <= 1'b1;
		hv <= {5'h00, a};
		repeat (4) @(posedge clk_i);
		ale_o <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask

	task automatic write_reg(input logic [2:0] a, input logic [7:0] d, input logic sel);
		addr_phase(a, sel);
		hv <= (a == 3'h4) ? (d & 8'h7f) : d;
		wr_n_o <= 1'b0;
		repeat (4) @(posedge clk_i);
		wr_n_o <= 1'b1;
		repeat (4) @(posedge clk_i);
		drv <= 1'b0;
		cs_n_o <= 1'b1;
		repeat (3) @(posedge clk_i);
	endtask

	task automatic read_reg(input logic [2:0] a, output logic [7:0] d, input logic sel);
		addr_phase(a, sel);
		drv <= 1'b0;
		rd_n_o <= 1'b0;
		repeat (6) @(posedge clk_i);
		d = ad_o;
		rd_n_o <= 1'b1;
		cs_n_o <= 1'b1;
		repeat (5) @(posedge clk_i);
	endtask
endmodule
`default_nettype wire

// ### test/mcr_bank_bench.sv
`default_nettype none
`include "mcr_defs.svh"
`define CHK(n, e, g) \
	begin \
		n_checks++; \
		if ((g) !== (e)) \
		begin \
			n_errors++; \
			$display("[ERR] %s expected %h seen %h", n, (e), (g)); \
		end \
	end
module mcr_bank_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import mcr_pkg::*;
	localparam int H2400 = 4;
	localparam int H1200 = 8;

	logic           clk_i = 1'b0;
	logic           rst_n_i = 1'b0;
	logic           tx_baud_clk_i = 1'b0;
	logic           rx_unscr_data_i = 1'b0;
	logic           xtal_echo_i = 1'b0;
	logic           ale_i, cs_n_i, rd_n_i, wr_n_i, ad_oe_o, int_o, int_oe_o, clk_pin_o;
	logic [7:0]     ad_i, ad_o;
	mcr_detect_t    detect_i = 8'h81;
	mcr_modem_ctl_t modem_o;
	mcr_tone_ctl_t  tone_o;
	int             n_errors = 0;
	int             n_checks = 0;
	int             cycles = 0;

	mcr_bank #(.HALF_2400(H2400), .HALF_1200(H1200), .HALF_600(16)) dut_u (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .ale_i(ale_i), .cs_n_i(cs_n_i), .rd_n_i(rd_n_i),
		.wr_n_i(wr_n_i), .ad_i(ad_i), .ad_o(ad_o), .ad_oe_o(ad_oe_o), .int_o(int_o),
		.int_oe_o(int_oe_o), .detect_i(detect_i), .tx_baud_clk_i(tx_baud_clk_i),
		.rx_unscr_data_i(rx_unscr_data_i), .xtal_echo_i(xtal_echo_i),
		.clk_pin_o(clk_pin_o), .modem_o(modem_o), .tone_o(tone_o));
	mcr_host_model host_u (.clk_i(clk_i), .dev_ad_i(ad_o), .dev_oe_i(ad_oe_o), .ale_o(ale_i),
		.cs_n_o(cs_n_i), .rd_n_o(rd_n_i), .wr_n_o(wr_n_i), .ad_o(ad_i));

	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) xtal_echo_i <= ~xtal_echo_i;
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_errors++;
			complete_run;
		end
	end

	task automatic complete_run;
		if (n_errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		host_u.write_reg(a, d, 1'b1);
	endtask

	task automatic rd_chk(input string n, input logic [2:0] a, input logic [7:0] e,
		input logic [7:0] m = 8'hff);
		logic [7:0] v;
		host_u.read_reg(a, v, 1'b1);
		`CHK(n, e & m, v & m)
	endtask

	task automatic poke(input int b, input logic e);
		@(posedge clk_i);
		detect_i <= detect_i ^ 8'(1 << b);
		repeat (8) @(posedge clk_i);
		`CHK("interrupt", e, int_oe_o)
	endtask

	task automatic t_reset;
		for (int a = 0; a < 8; a++)
			rd_chk("reset value", 3'(a), a == 2 ? 8'h81 : a == 5 ? `MCR_RST_GAIN :
				a == 6 ? {`MCR_SIG_CODE, 4'h0} : 8'h00, a == 6 ? 8'hf0 : 8'hff);
	endtask

	task automatic t_modes;
		logic [7:0] lm [5] = '{8'h50, 8'h10, 8'h90, 8'h20, 8'ha0};
		mcr_rate_t  rt [5] = '{MCR_RATE_2400, MCR_RATE_1200, MCR_RATE_600, MCR_RATE_300,
			MCR_RATE_V21};
		for (int i = 0; i < 4; i++)
		begin
			wr(3'h0, 8'h10 | 8'(i << 2) | 8'(i & 1));
			`CHK("data bits", 4'(6 + i), modem_o.data_bits)
			`CHK("char bits", 4'(8 + i), modem_o.char_bits)
			`CHK("tx band", i[0], modem_o.tx_low_band)
			`CHK("rx band", i[0], modem_o.rx_high_band)
			wr(3'h1, 8'(i) | 8'((i & 1) << 4));
			`CHK("test mode", 2'(i), modem_o.test)
			`CHK("loop carrier", i == 1, modem_o.rx_use_tx_carrier)
			`CHK("scr bypass", i[0], modem_o.scr_bypass)
		end
		for (int i = 0; i < 5; i++)
		begin
			wr(3'h0, lm[i]);
			`CHK("rate", rt[i], modem_o.rate)
		end
	endtask

	task automatic t_special;
		wr(3'h5, 8'h3a);
		wr(3'h4, 8'h40);
		@(posedge clk_i);
		tx_baud_clk_i <= 1'b1;
		wr(3'h5, 8'h0c);
		rd_chk("special", 3'h5, 8'h4c);
		`CHK("quality sel", 2'b10, modem_o.quality_threshold_sel)
		wr(3'h4, 8'h00);
		rd_chk("gain", 3'h5, 8'h3a);
	endtask

	task automatic t_tones;
		logic [2:0]    cf [4] = '{3'b101, 3'b111, 3'b000, 3'b110};
		mcr_det_tone_t dt [4] = '{MCR_DET_2225, MCR_DET_2100, MCR_DET_SCT_900, MCR_DET_EITHER};
		wr(3'h0, 8'h06);
		wr(3'h3, 8'h41);
		`CHK("guard tone", 1'b1, tone_o.guard_550)
		wr(3'h0, 8'h07);
		wr(3'h3, 8'h40);
		`CHK("calling tone", 1'b1, tone_o.calling_1300)
		wr(3'h3, 8'h15);
		`CHK("dtmf send", 1'b1, tone_o.dual_tone_send)
		`CHK("dtmf code", 4'h5, tone_o.dtmf_code)
		for (int i = 0; i < 4; i++)
		begin
			wr(3'h0, 8'h06 | 8'(cf[i][2]));
			wr(3'h3, 8'(cf[i][1]));
			wr(3'h4, 8'(cf[i][0]) << 5);
			`CHK("detect tone", dt[i], tone_o.det_tone)
		end
	endtask

	task automatic t_clock;
		int   h [2] = '{H1200, H2400};
		int   n;
		logic p;
		wr(3'h1, 8'h08);
		for (int j = 0; j < 2; j++)
		begin
			wr(3'h0, j ? 8'h50 : 8'h10);
			n = 0;
			p = clk_pin_o;
			repeat (64)
			begin
				@(negedge clk_i);
				n += int'(clk_pin_o !== p);
				p = clk_pin_o;
			end
			`CHK("clock toggles", 1'b1, n >= 64 / (h[j] + 1) - 1 && n <= 64 / h[j] + 1)
		end
		wr(3'h0, 8'h20);
		@(negedge clk_i);
		`CHK("crystal echo", xtal_echo_i, clk_pin_o)
	endtask

	task automatic t_bus;
		logic [7:0] v;
		wr(3'h0, 8'h10);
		host_u.write_reg(3'h0, 8'hff, 1'b0);
		rd_chk("unselected write", 3'h0, 8'h10);
		fork
			host_u.read_reg(3'h0, v, 1'b0);
			begin
				repeat (14) @(posedge clk_i);
				`CHK("unselected drive", 1'b0, ad_oe_o)
			end
		join
		wr(3'h7, 8'h55);
		rd_chk("unmapped", 3'h7, 8'h00);
		wr(3'h2, 8'h00);
		rd_chk("detect write", 3'h2, 8'h81);
		wr(3'h6, 8'h00);
		rd_chk("signature", 3'h6, {`MCR_SIG_CODE, 4'h0}, 8'hf0);
	endtask

	task automatic t_soft;
		wr(3'h0, 8'h57);
		wr(3'h3, 8'h15);
		wr(3'h5, 8'h3f);
		wr(3'h4, 8'h24);
		wr(3'h1, 8'h0c);
		for (int a = 0; a < 6; a++)
			if (a != 2)
				rd_chk("soft reset", 3'(a), a == 5 ? 8'h04 : 8'h00);
		`CHK("power down", 1'b1, modem_o.power_down)
		@(negedge clk_i);
		`CHK("reset echo", xtal_echo_i, clk_pin_o)
	endtask

	task automatic t_int;
		wr(3'h0, 8'h10);
		wr(3'h1, 8'h20);
		poke(3, 1'b1);
		repeat (20) @(posedge clk_i);
		`CHK("int held", 1'b1, int_oe_o)
		`CHK("int pin level", 1'b0, int_o)
		rd_chk("detect", 3'h2, detect_i);
		`CHK("int cleared", 1'b0, int_oe_o)
		poke(0, 1'b0);
		poke(6, 1'b1);
		rd_chk("detect", 3'h2, detect_i);
		wr(3'h0, 8'h12);
		poke(1, 1'b0);
		poke(2, 1'b0);
		wr(3'h3, 8'h10);
		poke(3, 1'b0);
		wr(3'h3, 8'h00);
		wr(3'h0, 8'h00);
		poke(3, 1'b0);
		wr(3'h0, 8'h10);
		wr(3'h1, 8'h00);
		poke(4, 1'b0);
	endtask

	initial
	begin
		repeat (16) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		t_reset;
		t_modes;
		t_special;
		t_tones;
		t_clock;
		t_bus;
		t_soft;
		t_int;
		complete_run;
	end
endmodule
`default_nettype wire
